/* File: rtl/auxc_pkg.sv */
// Package for the auxiliary control and emulation-mode block.
// Assumes a single core clock; register port is a plain strobe port.
package auxc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] AUX_CTRL_ADDR = 8'h8E;
    localparam logic [7:0] AUX_CTRL_RESET = 8'h0C;
    localparam logic [7:0] AUX_CTRL_WMASK = 8'hAF;
    localparam logic [7:0] STATUS_ADDR = 8'h8F;

    // ==========================================================
    // Field positions
    localparam int LATCH_DIS_BIT = 0;
    localparam int EXT_SEL_BIT = 1;
    localparam int SIZE_LO_BIT = 2;
    localparam int SIZE_HI_BIT = 3;
    localparam int STRETCH_BIT = 5;
    localparam int PULLUP_DIS_BIT = 7;

    // ==========================================================
    // Timing in core clock periods
    localparam logic [4:0] STROBE_SHORT = 5'h06;
    localparam logic [4:0] STROBE_LONG = 5'h1E;
    localparam logic [2:0] LATCH_DIV_X1 = 3'h6;
    localparam logic [2:0] LATCH_DIV_X2 = 3'h3;

    // ==========================================================
    // Expanded RAM sizes in bytes
    localparam logic [10:0] XRAM_256 = 11'h100;
    localparam logic [10:0] XRAM_512 = 11'h200;
    localparam logic [10:0] XRAM_768 = 11'h300;
    localparam logic [10:0] XRAM_1024 = 11'h400;

    typedef enum logic [1:0] {
        AUXC_ST_IDLE = 2'b00,
        AUXC_ST_ACTIVE = 2'b01
    } auxc_strobe_state_t;

    // Pin state for one pad group
    typedef struct packed {
        logic drive_en;
        logic weak_pullup;
        logic float_en;
    } auxc_pad_t;

endpackage

/* File: rtl/auxc_top.sv */
// Auxiliary control register and on-chip emulation-mode entry.
// Assumes pins sampled synchronously to core_clk; rst is the reset pin.
// Functional notes
// - Enter emulation mode on that pin sequence at reset.
// - Emulation: weak pull-up strobes and ports 1-3; float port 0, I2.
// - Leave emulation mode only by an ordinary reset.
// - Latch disable set: strobe only for data moves, table reads, fetches.
// - Suppressed latch strobe pin is weakly pulled high.
// - Latch disable clear: strobe at 1/6 clock, 1/3 in double speed.
// - Bit 7 set disables port weak pull-ups.
// - Bit 5 selects data strobe width, 6 or 30 clocks.
// - Bits 3:2 select expanded RAM size 256 to 1024 bytes.
// - Bit 1 routes data moves to internal RAM or external memory.
// - Reset loads 0X0X1100b.
// - Register at address 8Eh, byte access only.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module auxc_top
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic latch_pin_in,
    input wire logic prog_store_strobe_in,
    input wire logic double_speed_mode,
    input wire logic external_data_move,
    input wire logic code_table_read,
    input wire logic external_fetch,
    output logic latch_out,
    output logic latch_oe,
    output logic latch_weak_pullup,
    output logic prog_strobe_release,
    output auxc_pkg::auxc_pad_t port0_pad,
    output auxc_pkg::auxc_pad_t port123_pad,
    output auxc_pkg::auxc_pad_t port_i2_pad,
    output logic xtal_active,
    output logic onchip_emulation_mode,
    output logic data_strobe,
    output logic expanded_ram_sel,
    output logic [10:0] xram_size_bytes
);

    // ==========================================================
    // Register
    logic [7:0] auxiliary_control_reg;
    logic emul_reg;
    logic in_reset_reg;
    logic entry_ok_reg;
    logic [2:0] div_cnt_reg;
    logic [4:0] strobe_cnt_reg;
    logic move_d_reg;
    auxc_pkg::auxc_strobe_state_t strobe_state_reg;

    // Address decode / byte write
    // byte-wide access
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            auxiliary_control_reg <= auxc_pkg::AUX_CTRL_RESET;
        else if (reg_wr && reg_addr == auxc_pkg::AUX_CTRL_ADDR)
            auxiliary_control_reg <= reg_wdata & auxc_pkg::AUX_CTRL_WMASK;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd && reg_addr == auxc_pkg::AUX_CTRL_ADDR)
            reg_rdata <= auxiliary_control_reg;
        else if (reg_rd && reg_addr == auxc_pkg::STATUS_ADDR)
            reg_rdata <= {7'h00, emul_reg};
        else
            reg_rdata <= 8'h00;
    end

    // ==========================================================
    // Emulation entry
    // Entry qualifier tracked while reset pin is high and at the first clock after release
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            in_reset_reg <= 1'b1;
        else
            in_reset_reg <= 1'b0;
    end

    // condition checked during reset and at release
    always_ff @(posedge core_clk)
    begin
        if (in_reset_reg)
            entry_ok_reg <= !latch_pin_in && prog_store_strobe_in;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            emul_reg <= 1'b0;
        else if (in_reset_reg)
            emul_reg <= entry_ok_reg && !latch_pin_in;
    end

    // ==========================================================
    // Latch strobe generation
    // divide by 6 or 3
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            div_cnt_reg <= 3'h0;
        else if (div_cnt_reg >= (double_speed_mode ? auxc_pkg::LATCH_DIV_X2
                                                    : auxc_pkg::LATCH_DIV_X1) - 3'h1)
            div_cnt_reg <= 3'h0;
        else
            div_cnt_reg <= div_cnt_reg + 3'h1;
    end

    logic latch_active;
    // gated to external accesses when disabled
    assign latch_active = !auxiliary_control_reg[auxc_pkg::LATCH_DIS_BIT]
        || external_data_move || code_table_read || external_fetch;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            latch_out <= 1'b1;
            latch_oe <= 1'b0;
            latch_weak_pullup <= 1'b1;
            prog_strobe_release <= 1'b0;
            port0_pad <= '0;
            port123_pad <= '0;
            port_i2_pad <= '0;
            xtal_active <= 1'b1;
            onchip_emulation_mode <= 1'b0;
        end
        else
        begin
            onchip_emulation_mode <= emul_reg;
            xtal_active <= 1'b1;
            prog_strobe_release <= emul_reg;
            if (emul_reg)
            begin
                latch_out <= 1'b1;
                latch_oe <= 1'b0;
                latch_weak_pullup <= 1'b1;
                port0_pad <= '{drive_en: 1'b0, weak_pullup: 1'b0, float_en: 1'b1};
                port123_pad <= '{drive_en: 1'b0, weak_pullup: 1'b1, float_en: 1'b0};
                port_i2_pad <= '{drive_en: 1'b0, weak_pullup: 1'b0, float_en: 1'b1};
            end
            else
            begin
                latch_out <= latch_active && div_cnt_reg == 3'h0;
                latch_oe <= latch_active;
                latch_weak_pullup <= !latch_active;
                port0_pad <= '{drive_en: 1'b1, weak_pullup: 1'b0, float_en: 1'b0};
                port123_pad <= '{drive_en: 1'b1,
                    weak_pullup: !auxiliary_control_reg[auxc_pkg::PULLUP_DIS_BIT],
                    float_en: 1'b0};
                port_i2_pad <= '{drive_en: 1'b1,
                    weak_pullup: !auxiliary_control_reg[auxc_pkg::PULLUP_DIS_BIT],
                    float_en: 1'b0};
            end
        end
    end

    // ==========================================================
    // Data read/write strobe width
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            move_d_reg <= 1'b0;
        else
            move_d_reg <= external_data_move;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            strobe_state_reg <= auxc_pkg::AUXC_ST_IDLE;
            strobe_cnt_reg <= 5'h00;
            data_strobe <= 1'b0;
        end
        else
        begin
            case (strobe_state_reg)
                auxc_pkg::AUXC_ST_IDLE:
                begin
                    if (external_data_move && !move_d_reg && !emul_reg)
                    begin
                        strobe_state_reg <= auxc_pkg::AUXC_ST_ACTIVE;
                        data_strobe <= 1'b1;
                        strobe_cnt_reg <= auxiliary_control_reg[auxc_pkg::STRETCH_BIT]
                            ? auxc_pkg::STROBE_LONG - 5'h01
                            : auxc_pkg::STROBE_SHORT - 5'h01;
                    end
                end
                auxc_pkg::AUXC_ST_ACTIVE:
                begin
                    if (strobe_cnt_reg == 5'h00)
                    begin
                        strobe_state_reg <= auxc_pkg::AUXC_ST_IDLE;
                        data_strobe <= 1'b0;
                    end
                    else
                        strobe_cnt_reg <= strobe_cnt_reg - 5'h01;
                end
                default:
                begin
                    strobe_state_reg <= auxc_pkg::AUXC_ST_IDLE;
                    data_strobe <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Memory routing and size
    // internal or external
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            expanded_ram_sel <= 1'b1;
            xram_size_bytes <= auxc_pkg::XRAM_1024;
        end
        else
        begin
            expanded_ram_sel <= !auxiliary_control_reg[auxc_pkg::EXT_SEL_BIT];
            case (auxiliary_control_reg[auxc_pkg::SIZE_HI_BIT:auxc_pkg::SIZE_LO_BIT])
                2'h0: xram_size_bytes <= auxc_pkg::XRAM_256;
                2'h1: xram_size_bytes <= auxc_pkg::XRAM_512;
                2'h2: xram_size_bytes <= auxc_pkg::XRAM_768;
                default: xram_size_bytes <= auxc_pkg::XRAM_1024;
            endcase
        end
    end

    // ==========================================================
    // Checks
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
        (auxiliary_control_reg & ~auxc_pkg::AUX_CTRL_WMASK) == 8'h00)
        else $error("reserved bits set");
    a_write_takes: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == auxc_pkg::AUX_CTRL_ADDR |=>
        auxiliary_control_reg == ($past(reg_wdata) & auxc_pkg::AUX_CTRL_WMASK))
        else $error("write not stored");
    a_emul_sticky: assert property (@(posedge core_clk) disable iff (rst)
        !in_reset_reg && $past(!in_reset_reg) |-> $stable(emul_reg))
        else $error("emulation mode changed without reset");
    a_emul_pads: assert property (@(posedge core_clk) disable iff (rst)
        emul_reg |=> port0_pad.float_en && port123_pad.weak_pullup && !latch_oe)
        else $error("emulation pad state wrong");
    a_latch_gated: assert property (@(posedge core_clk) disable iff (rst)
        !emul_reg && auxiliary_control_reg[0] && !external_data_move
        && !code_table_read && !external_fetch |=> !latch_oe && latch_weak_pullup)
        else $error("latch strobe not suppressed");
    a_latch_period: assert property (@(posedge core_clk) disable iff (rst)
        !double_speed_mode && div_cnt_reg == 3'h0 |=> div_cnt_reg == 3'h1)
        else $error("latch divider wrong");
    a_strobe_short: assert property (@(posedge core_clk) disable iff (rst)
        $rose(data_strobe) && !auxiliary_control_reg[5] |-> data_strobe[*6] ##1 !data_strobe)
        else $error("short strobe width wrong");
    a_pullup_ctl: assert property (@(posedge core_clk) disable iff (rst)
        !emul_reg && $past(!emul_reg) && $past(!in_reset_reg) |-> port123_pad.weak_pullup
        == !$past(auxiliary_control_reg[7]))
        else $error("pull-up control wrong");
    a_ram_route: assert property (@(posedge core_clk) disable iff (rst)
        ##1 expanded_ram_sel == !$past(auxiliary_control_reg[1]))
        else $error("ram routing wrong");
    c_emul_entry: cover property (@(posedge core_clk) $rose(emul_reg));
    c_long_strobe: cover property (@(posedge core_clk)
        $rose(data_strobe) && auxiliary_control_reg[5]);
    c_latch_gated: cover property (@(posedge core_clk) auxiliary_control_reg[0] && latch_oe);
    c_double_speed: cover property (@(posedge core_clk) double_speed_mode && latch_out);

    // ==========================================================
    // Strobe length monitor
    // length of the current data strobe, cleared one clock after it ends
    logic [4:0] strobe_len_reg;
    logic strobe_long_reg;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            strobe_len_reg <= 5'h00;
            strobe_long_reg <= 1'b0;
        end
        else if (data_strobe)
            strobe_len_reg <= strobe_len_reg + 5'h01;
        else
        begin
            strobe_len_reg <= 5'h00;
            strobe_long_reg <= auxiliary_control_reg[auxc_pkg::STRETCH_BIT];
        end
    end

    a_strobe_long: assert property (@(posedge core_clk) disable iff (rst)
        $fell(data_strobe) && strobe_long_reg |-> strobe_len_reg == 5'h1E)
        else $error("long strobe width wrong");
    a_size_full: assert property (@(posedge core_clk) disable iff (rst)
        auxiliary_control_reg[3:2] == 2'h3 |=> xram_size_bytes == auxc_pkg::XRAM_1024)
        else $error("full ram size wrong");
    a_size_least: assert property (@(posedge core_clk) disable iff (rst)
        auxiliary_control_reg[3:2] == 2'h0 |=> xram_size_bytes == auxc_pkg::XRAM_256)
        else $error("least ram size wrong");
    a_emul_entry: assert property (@(posedge core_clk) disable iff (rst)
        in_reset_reg && entry_ok_reg && !latch_pin_in |=> emul_reg)
        else $error("emulation entry missed");
    a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not cleared");
    a_latch_fast: assert property (@(posedge core_clk) disable iff (rst)
        double_speed_mode && div_cnt_reg == 3'h2 |=> div_cnt_reg == 3'h0)
        else $error("double speed divider wrong");
    a_emul_quiet: assert property (@(posedge core_clk) disable iff (rst)
        emul_reg && !data_strobe |=> !data_strobe)
        else $error("data strobe in emulation");

endmodule
`default_nettype wire

/* File: bench/auxc_emul_model.sv */
// Emulator model driving the latch and program strobe pins.
// Assumes rst is the reset pin shared with the device.
`timescale 1ns/1ps
`default_nettype none
module auxc_emul_model
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic emul_req,
    output logic latch_pin_in,
    output logic prog_store_strobe_in
);
    logic [2:0] hold_reg;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            hold_reg <= 3'h4;
        else if (hold_reg != 3'h0)
            hold_reg <= hold_reg - 3'h1;
    end
    // Released pin sits at its weak pull-up
    assign latch_pin_in = (emul_req && (rst || hold_reg != 3'h0)) ? 1'b0 : 1'b1;
    assign prog_store_strobe_in = 1'b1;
endmodule
`default_nettype wire

/* File: bench/auxc_bench.sv */
// Self-checking bench for the auxiliary control block.
// Assumes a 25 MHz core clock and the emulator model on the pins.
`timescale 1ns/1ps
`default_nettype none
module auxc_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic emul_req = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic latch_pin_in, prog_store_strobe_in;
    logic double_speed_mode = 1'b0;
    logic external_data_move = 1'b0;
    logic code_table_read = 1'b0;
    logic external_fetch = 1'b0;
    logic latch_out, latch_oe, latch_weak_pullup, prog_strobe_release;
    auxc_pkg::auxc_pad_t port0_pad, port123_pad, port_i2_pad;
    logic xtal_active, onchip_emulation_mode, data_strobe, expanded_ram_sel;
    logic [10:0] xram_size_bytes;
    int fail_count = 0;
    int cmp_count = 0;
    int cnt;

    always #20 core_clk = ~core_clk;

    auxc_top auxc_top_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .latch_pin_in(latch_pin_in), .prog_store_strobe_in(prog_store_strobe_in),
        .double_speed_mode(double_speed_mode), .external_data_move(external_data_move),
        .code_table_read(code_table_read), .external_fetch(external_fetch),
        .latch_out(latch_out), .latch_oe(latch_oe), .latch_weak_pullup(latch_weak_pullup),
        .prog_strobe_release(prog_strobe_release), .port0_pad(port0_pad),
        .port123_pad(port123_pad), .port_i2_pad(port_i2_pad), .xtal_active(xtal_active),
        .onchip_emulation_mode(onchip_emulation_mode), .data_strobe(data_strobe),
        .expanded_ram_sel(expanded_ram_sel), .xram_size_bytes(xram_size_bytes));

    auxc_emul_model auxc_emul_model_i (.core_clk(core_clk), .rst(rst), .emul_req(emul_req),
        .latch_pin_in(latch_pin_in), .prog_store_strobe_in(prog_store_strobe_in));

    // ==========================================================
    // Shared tasks
    task chk(input string name, input logic [10:0] exp, input logic [10:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, {3'h0, exp}, {3'h0, reg_rdata});
    endtask

    task count_latch(input int n);
        cnt = 0;
        repeat (n)
        begin
            @(posedge core_clk);
            #1;
            cnt += (latch_oe === 1'b1 && latch_out === 1'b1) ? 1 : 0;
        end
    endtask

    task do_reset(input logic emul);
        @(posedge core_clk);
        emul_req <= emul;
        rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task test_regs;
        rd(8'h8E, 8'h0C, "reset_value");
        chk("size_reset", 11'h400, xram_size_bytes);
        wr(8'h8E, 8'hFF);
        rd(8'h8E, 8'hAF, "reserved_bits");
        rd(8'h8C, 8'h00, "unmapped");
        chk("ext_sel", 11'h000, {10'h0, expanded_ram_sel});
        chk("pullup_off", 11'h000, {10'h0, port123_pad.weak_pullup});
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h8E, 8'(i << 2));
            chk("xram_size", 11'(11'h100 * (i + 1)), xram_size_bytes);
            chk("int_sel", 11'h001, {10'h0, expanded_ram_sel});
            chk("pullup_on", 11'h001, {10'h0, port123_pad.weak_pullup});
        end
    endtask

    task test_latch;
        wr(8'h8E, 8'h0C);
        count_latch(12);
        chk("latch_x1", 11'h002, 11'(cnt));
        double_speed_mode <= 1'b1;
        @(posedge core_clk);
        count_latch(12);
        chk("latch_x2", 11'h004, 11'(cnt));
        double_speed_mode <= 1'b0;
        wr(8'h8E, 8'h0D);
        count_latch(12);
        chk("latch_off", 11'h000, 11'(cnt));
        chk("latch_weak", 11'h001, {10'h0, latch_weak_pullup});
        for (int i = 0; i < 3; i++)
        begin
            {external_data_move, code_table_read, external_fetch} <= 3'h4 >> i;
            @(posedge core_clk);
            count_latch(12);
            chk("latch_active", 11'h001, {10'h0, cnt != 0});
            {external_data_move, code_table_read, external_fetch} <= 3'h0;
            repeat (40) @(posedge core_clk);
        end
    endtask

    task test_strobe(input logic [7:0] val, input int width);
        wr(8'h8E, val);
        @(posedge core_clk);
        external_data_move <= 1'b1;
        @(posedge core_clk);
        external_data_move <= 1'b0;
        cnt = 0;
        repeat (45)
        begin
            #1;
            cnt += (data_strobe === 1'b1) ? 1 : 0;
            @(posedge core_clk);
        end
        chk("strobe_width", 11'(width), 11'(cnt));
    endtask

    task test_emulation;
        do_reset(1'b1);
        chk("emul_pins", 11'h07F, {4'h0, onchip_emulation_mode, port0_pad.float_en,
            port_i2_pad.float_en, port123_pad.weak_pullup, latch_weak_pullup,
            prog_strobe_release, xtal_active});
        repeat (20) @(posedge core_clk);
        rd(8'h8F, 8'h01, "emul_held");
        do_reset(1'b0);
        chk("emul_exit", 11'h000, {10'h0, onchip_emulation_mode});
    endtask

    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #200000;
        fail_count++;
        results();
    end

    initial
    begin
        do_reset(1'b0);
        test_regs();
        test_latch();
        test_strobe(8'h0C, 6);
        test_strobe(8'h2C, 30);
        test_emulation();
        results();
    end
endmodule
`default_nettype wire
